// ===== fanout_ctl_regs.svh
// Purpose: Offsets, field positions and reset values of the fan-out control bytes
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef FANOUT_CTL_REGS_SVH
`define FANOUT_CTL_REGS_SVH

// ****************************************
// Serial link constants
// ****************************************
`define SLAVE_ADDR 7'h6E
`define READ_COUNT 8'h02
`define BYTE_LAST_BIT 4'h7
`define ACK_SLOT 4'h8

// ****************************************
// Register indexes and reset values
// ****************************************
`define IDX_MODE_CTL 8'h00
`define IDX_OE_CTL 8'h01
`define MODE_CTL_RST 8'h07
`define OE_CTL_RST 8'h66
`define MODE_CTL_MASK 8'hC7
`define OE_CTL_MASK 8'h66

// ****************************************
// Field positions
// ****************************************
`define MODE_NORMAL_BIT 0
`define MODE_PLL_BIT 1
`define MODE_LOWBW_BIT 2
`define MODE_STOP_FLOAT_BIT 6
`define MODE_PD_FLOAT_BIT 7
`define OE_PAIR0_BIT 1
`define OE_PAIR1_BIT 2
`define OE_PAIR2_BIT 5
`define OE_PAIR3_BIT 6

`endif

// ===== fanout_ctl_pkg.sv
// Purpose: Types shared by the fan-out control design
// Assumes: Nothing
// Notes:   Constants live in fanout_ctl_regs.svh
package fanout_ctl_pkg;
   // Phases of the serial slave
   typedef enum logic [2:0] {
      ph_idle,
      ph_addr,
      ph_index,
      ph_count,
      ph_wdata,
      ph_tx,
      ph_ignore
   } link_phase_e;
endpackage

// ===== sync2.sv
// Purpose: Two-flop synchroniser for levels entering the system clock
// Assumes: Each bit is an independent level
// Notes:   The first stage is read by the second stage only
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r; // First stage, may go metastable
   logic [W-1:0] q_r; // Second stage, safe to use

   // Two stages on every rising edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule

// ===== smbus_link_rx.sv
// Purpose: Link-clock side of the serial port, one sample per link clock rise
// Assumes: The link clock only moves inside frames
// Notes:   Data bit is held stable until the next rise; the toggle marks it
`timescale 1ns/1ps
module smbus_link_rx (
   input wire logic link_clock,
   input wire logic rst_n,
   input wire logic sda_in,
   output logic bit_r,
   output logic bit_tog_r
);
   // ****************************************
   // Bit capture
   // ****************************************
   // Sample data on the rising link clock and flip the event toggle.
   // Data and toggle change together; the reader waits for the synced
   // toggle, by which time the held bit is long settled.
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_r <= 1'b1;
         bit_tog_r <= 1'b0;
      end else begin
         bit_r <= sda_in;
         bit_tog_r <= ~bit_tog_r;
      end
   end
endmodule

// ===== fanout_ctl.sv
// Purpose: Serial control slave and output gating of a 1:4 clock fan-out
// Assumes: clock 200 MHz; sclk at least ten times slower than clock
// Notes:   Start and stop come from the oversampled lines
// Behaviour
// - Slave only, one fixed address, block transfers
// - Address 1101110, then write 0, read 1
// - Order: address, index, count, data, acks
// - Stop or power-down halts the clock outputs
// - Invert input flips oe, stop, power-down pins
// - Two active-high pins enable pairs 0, 3
// - Path pin picks PLL or direct fan-out
// - Stop and power-down pins are active low
// - Bandwidth pin picks PLL loop bandwidth
// - Mode bit 0: 0 halves frequency, resets 1
// - Mode bit 1: 0 bypass, 1 PLL, resets 1
// - Mode bit 2: 0 high, 1 low bandwidth
// - Bits 6, 7 float outputs in stop, power-down
// - Enable byte bits 1,2,5,6 gate pairs 0-3
`timescale 1ns/1ps
`include "fanout_ctl_regs.svh"
module fanout_ctl (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic clock_stop_n,
   input wire logic power_down_n,
   input wire logic polarity_invert_sel,
   input wire logic oe_pair0,
   input wire logic oe_pair3,
   input wire logic path_sel,
   input wire logic loop_bw_sel,
   output logic [3:0] pair_run,
   output logic [3:0] pair_float,
   output logic div2_mode,
   output logic pll_path,
   output logic low_bw,
   output fanout_ctl_pkg::link_phase_e phase
);
   import fanout_ctl_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic link_bit; // Held bit from link domain
   logic link_tog; // Event toggle from link domain
   logic [9:0] sync_q; // Synced pins and link signals
   logic tog_s, scl_s, sda_s; // Synced link signals
   logic stop_s, pd_s, inv_s; // Synced control pins
   logic oe0_s, oe3_s, path_s, bw_s; // Synced control pins
   logic tog_d_r, scl_d_r, sda_d_r; // Previous synced values
   logic rise_ev, fall_ev; // Link clock edges
   logic start_ev, stop_ev; // Frame boundaries
   logic byte_done, ack_rise; // Eighth bit and ack slot
   logic [7:0] rx_nxt; // Shift value with new bit
   logic stop_act, pd_act; // Effective stop and power-down
   logic oe0_eff, oe3_eff; // Effective pin enables
   link_phase_e phase_r; // Slave phase
   logic [3:0] bit_cnt_r; // Rises within a byte
   logic [7:0] rx_sr_r, tx_sr_r; // Received bits and bits to send
   logic [7:0] idx_r, cnt_r; // Register index and write bytes left
   logic ack_r; // Ack due in next slot
   logic [7:0] mode_ctl_r, oe_ctl_r; // Mode and output enable bytes
   logic sda_oe_r, sda_out_r; // Pull-down enable; level, always low
   logic [3:0] pair_run_r, pair_float_r; // Pair gating
   logic div2_r, pll_path_r, low_bw_r; // Analog selects

   // Register read mux for the transmit data load
   function automatic logic [7:0] reg_read(input logic [7:0] i,
                                           input logic [7:0] m,
                                           input logic [7:0] o);
      if (i == `IDX_MODE_CTL) begin
         return m;
      end else if (i == `IDX_OE_CTL) begin
         return o;
      end else begin
         return 8'h00; // Unmapped index reads zero
      end
   endfunction

   // ****************************************
   // Link domain and synchronisers
   // ****************************************
   // Bit capture runs on the link's own clock
   smbus_link_rx u_link (
      .link_clock(sclk),
      .rst_n(rst_n),
      .sda_in(sda_in),
      .bit_r(link_bit),
      .bit_tog_r(link_tog)
   );

   // All pins and the event toggle pass two flops
   sync2 #(.W(10)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d({link_tog, sclk, sda_in, clock_stop_n, power_down_n,
          polarity_invert_sel, oe_pair0, oe_pair3, path_sel, loop_bw_sel}),
      .q(sync_q)
   );

   assign {tog_s, scl_s, sda_s, stop_s, pd_s, inv_s,
           oe0_s, oe3_s, path_s, bw_s} = sync_q;

   // ****************************************
   // Event decode
   // ****************************************
   // Delayed copies reset like the synchroniser, so no false edge follows reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tog_d_r <= 1'b0;
         scl_d_r <= 1'b0;
         sda_d_r <= 1'b0;
      end else begin
         tog_d_r <= tog_s;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   assign rise_ev = tog_s ^ tog_d_r;
   assign fall_ev = scl_d_r & ~scl_s;
   assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign rx_nxt = {rx_sr_r[6:0], link_bit};
   assign byte_done = rise_ev && (bit_cnt_r == `BYTE_LAST_BIT);
   assign ack_rise = rise_ev && (bit_cnt_r == `ACK_SLOT);

   // Pin sense, flipped by the invert input
   assign oe0_eff = oe0_s ^ inv_s;
   assign oe3_eff = oe3_s ^ inv_s;
   assign stop_act = ~(stop_s ^ inv_s);
   assign pd_act = ~(pd_s ^ inv_s);

   // ****************************************
   // Slave phase
   // ****************************************
   // Power-down parks the slave; the host leaves the lines alone then
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= ph_idle;
      end else if (pd_act || stop_ev) begin
         phase_r <= ph_idle;
      end else if (start_ev) begin
         phase_r <= ph_addr; // Also a repeated start
      end else if (byte_done) begin
         case (phase_r)
            ph_addr: begin
               if (rx_nxt[7:1] != `SLAVE_ADDR) begin
                  phase_r <= ph_ignore;
               end else if (rx_nxt[0]) begin
                  phase_r <= ph_tx; // Read: count goes out first
               end else begin
                  phase_r <= ph_index;
               end
            end
            ph_index: phase_r <= ph_count;
            ph_count: phase_r <= (rx_nxt == 8'h00) ? ph_ignore : ph_wdata;
            ph_wdata: begin
               if (cnt_r <= 8'h01) begin
                  phase_r <= ph_ignore; // Surplus bytes get no ack
               end
            end
            default: phase_r <= phase_r;
         endcase
      end else if (ack_rise && phase_r == ph_tx && link_bit && !ack_r) begin
         phase_r <= ph_ignore; // Host ended the read
      end
   end

   // Bit position inside the byte plus ack slot
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_r <= 4'h0;
      end else if (start_ev || stop_ev) begin
         bit_cnt_r <= 4'h0;
      end else if (rise_ev) begin
         bit_cnt_r <= (bit_cnt_r == `ACK_SLOT) ? 4'h0 : bit_cnt_r + 4'h1;
      end
   end

   // Receive shifter
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_sr_r <= 8'h00;
      end else if (rise_ev) begin
         rx_sr_r <= rx_nxt;
      end
   end

   // Ack owed for the byte just taken
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else if (start_ev || stop_ev || ack_rise) begin
         ack_r <= 1'b0;
      end else if (byte_done) begin
         case (phase_r)
            ph_addr: ack_r <= (rx_nxt[7:1] == `SLAVE_ADDR);
            ph_index: ack_r <= 1'b1;
            ph_count: ack_r <= 1'b1;
            ph_wdata: ack_r <= (cnt_r != 8'h00);
            default: ack_r <= 1'b0; // Sending or ignoring
         endcase
      end
   end

   // ****************************************
   // Index and count
   // ****************************************
   // Index set by the host, then stepped per data byte
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         idx_r <= 8'h00;
      end else if (byte_done && phase_r == ph_index) begin
         idx_r <= rx_nxt;
      end else if (byte_done && phase_r == ph_wdata && cnt_r != 8'h00) begin
         idx_r <= idx_r + 8'h01;
      end else if (ack_rise && phase_r == ph_tx && !ack_r && !link_bit) begin
         idx_r <= idx_r + 8'h01;
      end
   end

   // Remaining write bytes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else if (byte_done && phase_r == ph_count) begin
         cnt_r <= rx_nxt;
      end else if (byte_done && phase_r == ph_wdata && cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   // ****************************************
   // Control bytes
   // ****************************************
   // Writes land on the eighth bit; reserved bits stay zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_ctl_r <= `MODE_CTL_RST;
         oe_ctl_r <= `OE_CTL_RST;
      end else if (byte_done && phase_r == ph_wdata && cnt_r != 8'h00) begin
         if (idx_r == `IDX_MODE_CTL) begin
            mode_ctl_r <= rx_nxt & `MODE_CTL_MASK;
         end else if (idx_r == `IDX_OE_CTL) begin
            oe_ctl_r <= rx_nxt & `OE_CTL_MASK;
         end
      end
   end

   // ****************************************
   // Transmit and line drive
   // ****************************************
   // Count byte first, then registers from the index
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_sr_r <= 8'h00;
      end else if (byte_done && phase_r == ph_addr && rx_nxt[0]) begin
         tx_sr_r <= `READ_COUNT;
      end else if (ack_rise && phase_r == ph_tx && !ack_r && !link_bit) begin
         tx_sr_r <= reg_read(idx_r, mode_ctl_r, oe_ctl_r); // Host ack, not our own
      end else if (fall_ev && phase_r == ph_tx && bit_cnt_r < `ACK_SLOT) begin
         tx_sr_r <= {tx_sr_r[6:0], 1'b0};
      end
   end

   // Line changes after the link clock falls, and is released on start, stop or power-down; open drain, level stays low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_r <= 1'b0;
         sda_out_r <= 1'b0; // Only the enable pulls the line
      end else if (start_ev || stop_ev || pd_act) begin
         sda_oe_r <= 1'b0;
      end else if (fall_ev) begin
         if (bit_cnt_r == `ACK_SLOT) begin
            sda_oe_r <= ack_r;
         end else if (phase_r == ph_tx) begin
            sda_oe_r <= ~tx_sr_r[7];
         end else begin
            sda_oe_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // Output gating
   // ****************************************
   // Pin and register disables combine; stop and power-down win
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pair_run_r <= 4'h0;
         pair_float_r <= 4'h0;
      end else begin
         pair_run_r <= {oe_ctl_r[`OE_PAIR3_BIT] & oe3_eff,
                        oe_ctl_r[`OE_PAIR2_BIT],
                        oe_ctl_r[`OE_PAIR1_BIT],
                        oe_ctl_r[`OE_PAIR0_BIT] & oe0_eff}
                       & {4{~(stop_act | pd_act)}};
         pair_float_r <= {4{(stop_act & mode_ctl_r[`MODE_STOP_FLOAT_BIT])
                            | (pd_act & mode_ctl_r[`MODE_PD_FLOAT_BIT])}};
      end
   end

   // Frequency, path and bandwidth selects
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div2_r <= 1'b0;
         pll_path_r <= 1'b1;
         low_bw_r <= 1'b1;
      end else begin
         div2_r <= ~mode_ctl_r[`MODE_NORMAL_BIT];
         pll_path_r <= path_s & mode_ctl_r[`MODE_PLL_BIT];
         low_bw_r <= ~bw_s | mode_ctl_r[`MODE_LOWBW_BIT];
      end
   end

   assign sda_out = sda_out_r;
   assign sda_oe = sda_oe_r;
   assign pair_run = pair_run_r;
   assign pair_float = pair_float_r;
   assign div2_mode = div2_r;
   assign pll_path = pll_path_r;
   assign low_bw = low_bw_r;
   assign phase = phase_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_addr_mismatch: assert property (byte_done && phase_r == ph_addr
      && !pd_act && !start_ev && !stop_ev && rx_nxt[7:1] != `SLAVE_ADDR
      |=> phase_r == ph_ignore && !ack_r) else $error("foreign address accepted");
   a_addr_write: assert property (byte_done && phase_r == ph_addr
      && !pd_act && !start_ev && !stop_ev && rx_nxt == {`SLAVE_ADDR, 1'b0}
      |=> phase_r == ph_index && ack_r) else $error("own write address not taken");
   a_stop_halt: assert property (stop_act |=> pair_run_r == 4'h0)
      else $error("pairs run while stopped");
   a_inv_oe0: assert property (inv_s && oe0_s |=> !pair_run_r[0])
      else $error("inverted enable not honoured");
   a_oe3_pin: assert property (!inv_s && !oe3_s |=> !pair_run_r[3])
      else $error("pair 3 runs with pin low");
   a_path_pin: assert property (!path_s |=> !pll_path_r)
      else $error("pll path with bypass pin");
   a_bw_pin: assert property (!bw_s |=> low_bw_r)
      else $error("bandwidth pin ignored");
   a_div_mode: assert property (!mode_ctl_r[`MODE_NORMAL_BIT] |=> div2_r)
      else $error("divide mode not applied");
   a_float_stop: assert property (stop_act && mode_ctl_r[`MODE_STOP_FLOAT_BIT]
      |=> pair_float_r == 4'hF) else $error("stop float not applied");
   a_pair1_reg: assert property (!oe_ctl_r[`OE_PAIR1_BIT] |=> !pair_run_r[1])
      else $error("pair 1 runs while disabled");
   a_index_step: assert property (byte_done && phase_r == ph_wdata && cnt_r != 8'h00
      |=> idx_r == 8'($past(idx_r) + 8'h01)) else $error("index did not step");
   c_write_byte: cover property (byte_done && phase_r == ph_wdata && cnt_r != 8'h00);
   c_read_data: cover property (ack_rise && phase_r == ph_tx && !ack_r && !link_bit);
   c_power_down: cover property (pd_act && phase_r != ph_idle ##1 phase_r == ph_idle);
endmodule

// ===== smbus_host_model.sv
// Purpose: Behavioural serial host that frames block transfers for the control slave
// Assumes: Open-drain data line with a pull-up; link clock idles high between frames
// Notes:   Half period 32 ns gives the 64 ns link clock; no clock outside frames
`timescale 1ns/1ps
module smbus_host_model (
   output logic sclk,
   output logic host_pull,
   input wire logic sda
);
   // ****************************************
   // Link timing
   // ****************************************
   localparam time HALF = 32ns; // Half of the 64 ns link period
   localparam time SKEW = 8ns; // Data moves well after the falling edge

   // Idle bus: clock high, data released
   initial begin
      sclk = 1'b1;
      host_pull = 1'b0;
   end

   // ****************************************
   // Bit level
   // ****************************************
   // One clocked bit; data changes only while the clock is low, never at the edge itself
   task automatic clk_bit(input logic b, output logic s);
      #SKEW;
      host_pull = ~b;
      #(HALF - SKEW);
      sclk = 1'b1;
      s = sda;
      #HALF;
      sclk = 1'b0;
   endtask

   // Start or repeated start: data falls while clock high
   task automatic send_start();
      #SKEW;
      host_pull = 1'b0;
      #HALF;
      sclk = 1'b1;
      #HALF;
      host_pull = 1'b1;
      #HALF;
      sclk = 1'b0;
   endtask

   // Stop, then both lines left undriven, which also suits power-down
   task automatic send_stop();
      #SKEW;
      host_pull = 1'b1;
      #HALF;
      sclk = 1'b1;
      #HALF;
      host_pull = 1'b0;
   endtask

   // ****************************************
   // Byte level, MSB first
   // ****************************************
   // Address byte carries 1101110 plus direction, or foreign address 1110000 in one test; callers never pass a zero count
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, s);
      ack = ~s;
   endtask

   // Host releases data for eight bits, then acks or nacks
   task automatic read_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, d[i]);
      end
      clk_bit(nack, s);
   endtask
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the fan-out control slave and output gating
// Assumes: Host model on the serial pins; pins driven on clock rising edges
// Notes:   Pin changes are given five clock edges to pass the synchronisers
`timescale 1ns/1ps
module testbench;
   import fanout_ctl_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, host_pull, sda, sda_out, sda_oe;
   logic clock_stop_n = 1'b1; // Pins start in the running state
   logic power_down_n = 1'b1;
   logic polarity_invert_sel = 1'b0;
   logic oe_pair0 = 1'b1;
   logic oe_pair3 = 1'b1;
   logic path_sel = 1'b1;
   logic loop_bw_sel = 1'b1;
   logic [3:0] pair_run, pair_float;
   logic div2_mode, pll_path, low_bw;
   link_phase_e phase; // Slave phase, watched between frames
   int err_total = 0;
   int checks = 0;
   int cycles = 0;

   // 200 MHz system clock
   always #2.5 clock = ~clock;

   // Wired-AND data line with pull-up
   assign sda = ~host_pull & ~(sda_oe & ~sda_out);

   smbus_host_model u_host (.sclk(sclk), .host_pull(host_pull), .sda(sda));

   fanout_ctl u_dut (.clock(clock), .rst_n(rst_n), .sclk(sclk), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .clock_stop_n(clock_stop_n),
      .power_down_n(power_down_n), .polarity_invert_sel(polarity_invert_sel),
      .oe_pair0(oe_pair0), .oe_pair3(oe_pair3), .path_sel(path_sel),
      .loop_bw_sel(loop_bw_sel), .pair_run(pair_run), .pair_float(pair_float),
      .div2_mode(div2_mode), .pll_path(pll_path), .low_bw(low_bw), .phase(phase));

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t flag got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t value got %h exp %h", $time, got, exp);
      end
   endtask

   // Hang guard, well above the expected few thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         $display("ERROR %0t run too long", $time);
         report_and_stop();
      end
   end

   // ****************************************
   // Serial transfers
   // ****************************************
   // Indexed block write; every byte must be acked
   task automatic blk_write(input logic [7:0] idx, input logic [7:0] d[$]);
      logic a;
      u_host.send_start();
      u_host.write_byte(8'hDC, a);
      chk_flag(a, 1'b1);
      u_host.write_byte(idx, a);
      chk_flag(a, 1'b1);
      u_host.write_byte(8'(d.size()), a);
      chk_flag(a, 1'b1);
      foreach (d[i]) begin
         u_host.write_byte(d[i], a);
         chk_flag(a, 1'b1);
      end
      u_host.send_stop();
      repeat (4) @(posedge clock);
   endtask

   // Indexed block read; last byte nacked to end it
   task automatic blk_read(input logic [7:0] idx, input logic [7:0] e[$]);
      logic a;
      logic [7:0] v;
      u_host.send_start();
      u_host.write_byte(8'hDC, a);
      u_host.write_byte(idx, a);
      u_host.write_byte(8'(e.size()), a);
      u_host.send_start();
      u_host.write_byte(8'hDD, a);
      chk_flag(a, 1'b1);
      u_host.read_byte(1'b0, v);
      chk_byte(v, 8'h02);
      foreach (e[i]) begin
         u_host.read_byte(i == e.size() - 1, v);
         chk_byte(v, e[i]);
      end
      u_host.send_stop();
      repeat (4) @(posedge clock);
   endtask

   // Settle a pin change through the synchronisers
   task automatic settle();
      repeat (5) @(posedge clock);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic a;
      logic inv, stp, pd, e0, e3;
      logic [7:0] m;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      settle();
      // Power-up values of both control bytes
      chk_flag(div2_mode, 1'b0);
      chk_flag(pll_path, 1'b1);
      chk_flag(low_bw, 1'b1);
      chk_byte({4'h0, pair_float}, 8'h00);
      chk_byte({4'h0, pair_run}, 8'h0F);
      chk_byte({6'h00, sda_oe, sda_out}, 8'h00);
      blk_read(8'h00, '{8'h07, 8'h66});
      // Two-byte write, reserved bits must read back clear
      blk_write(8'h00, '{8'hFE, 8'h00});
      chk_flag(div2_mode, 1'b1);
      chk_byte({4'h0, pair_run}, 8'h00);
      blk_read(8'h00, '{8'hC6, 8'h00});
      // Each enable bit reaches its own pair
      blk_write(8'h01, '{8'h24});
      chk_byte({4'h0, pair_run}, 8'h06);
      blk_write(8'h01, '{8'h42});
      chk_byte({4'h0, pair_run}, 8'h09);
      // Bypass and high bandwidth, then the pins override
      blk_write(8'h00, '{8'h01});
      chk_flag(pll_path, 1'b0);
      chk_flag(low_bw, 1'b0);
      @(posedge clock);
      loop_bw_sel <= 1'b0;
      settle();
      chk_flag(low_bw, 1'b1);
      blk_write(8'h00, '{8'h03});
      chk_flag(pll_path, 1'b1);
      path_sel <= 1'b0;
      settle();
      chk_flag(pll_path, 1'b0);
      // Wrong address is not acked; unmapped index reads zero
      u_host.send_start();
      u_host.write_byte(8'hE0, a);
      chk_flag(a, 1'b0);
      u_host.send_stop();
      settle();
      chk_byte({5'h00, phase}, {5'h00, ph_idle});
      blk_read(8'h05, '{8'h00});
      blk_write(8'h01, '{8'h66});
      // Every invert, enable, stop and power-down pin combination, with stop-float then power-down-float
      for (int r = 0; r < 2; r++) begin
         m = r ? 8'h87 : 8'h47;
         blk_write(8'h00, '{m});
         for (int k = 0; k < 32; k++) begin
            @(posedge clock);
            {polarity_invert_sel, oe_pair0, oe_pair3, clock_stop_n, power_down_n} <= 5'(k);
            settle();
            inv = k[4];
            e0 = k[3] ^ inv;
            e3 = k[2] ^ inv;
            stp = ~(k[1] ^ inv);
            pd = ~(k[0] ^ inv);
            chk_byte({4'h0, pair_run}, {4'h0, {e3, 2'b11, e0} & {4{~(stp | pd)}}});
            chk_byte({4'h0, pair_float}, {4'h0, {4{(m[6] & stp) | (m[7] & pd)}}});
         end
         // Back to running pins before the bus is used again
         @(posedge clock);
         {polarity_invert_sel, oe_pair0, oe_pair3, clock_stop_n, power_down_n} <= 5'h0F;
         settle();
      end
      report_and_stop();
   end
endmodule
